// File: logic/adapter_pkg.sv
// Types shared by the diskette adapter host port
package adapter_pkg;
   // Live drive lines, packed in result byte order D7..D0
   typedef struct packed {
      logic       drive_fault;
      logic       write_protect;
      logic       drive_ready;
      logic       home_track;
      logic       double_sided;
      logic       side_select;
      logic       unit_sel_hi;
      logic       unit_sel_lo;
   } drive_lines_t;
   // Single-cycle event pulses from the controller core
   typedef struct packed {
      logic       past_end;
      logic       crc_id;
      logic       crc_data;
      logic       late;
      logic       not_found;
      logic       protected_hit;
      logic       no_id_mark;
      logic       no_data_mark;
      logic       deleted_mark;
      logic       scan_equal;
      logic       scan_unmet;
      logic [7:0] cyl_media;
      logic [7:0] cyl_wanted;
   } op_events_t;
   // The three result bytes
   typedef struct packed {
      logic [7:0] error_flags;
      logic [7:0] media_flags;
      logic [7:0] drive_lines;
   } result_bytes_t;
   typedef enum logic [5:0] {
      CMD_READ   = 6'h01,
      CMD_WRITE  = 6'h02,
      CMD_WRDEL  = 6'h04,
      CMD_FORMAT = 6'h08,
      CMD_SCAN   = 6'h10,
      CMD_OTHER  = 6'h20
   } cmd_kind_t;
   typedef enum logic [2:0] {
      OP_IDLE   = 3'h1,
      OP_EXEC   = 3'h2,
      OP_RESULT = 3'h4
   } op_state_t;
endpackage : adapter_pkg

// File: logic/adapter_regs.svh
// Register offsets, field positions and reset values of the diskette adapter
`ifndef ADAPTER_REGS_SVH
`define ADAPTER_REGS_SVH
`define ADDR_DATA_PORT    10'h3f5
`define ADDR_STATE_PORT   10'h3f4
`define ADDR_DRIVE_OUT    10'h3f2
`define DOR_RESET_VAL     8'h00
`define DOR_SEL_LSB       0
`define DOR_CTRL_RUN_BIT  2
`define DOR_IRQ_EN_BIT    3
`define DOR_MOTOR_LSB     4
`define ST_PAST_END_BIT   7
`define ST_CRC_BIT        5
`define ST_LATE_BIT       4
`define ST_MISSING_BIT    2
`define ST_BLOCKED_BIT    1
`define ST_ID_SYNC_BIT    0
`define ST_DELETED_BIT    6
`define ST_PCRC_BIT       5
`define ST_TRACK_BIT      4
`define ST_HIT_BIT        3
`define ST_MISS_BIT       2
`define ST_BAD_BIT        1
`define ST_DSYNC_BIT      0
`define BAD_TRACK_VAL     8'hff
`define MSR_REQ_BIT       7
`define MSR_DIR_BIT       6
`define MSR_BUSY_BIT      4
`endif

// File: logic/diskette_adapter.sv
// Diskette adapter host port: bus decode, drive output control, result bytes
`timescale 1ns/1ps
`default_nettype none
`include "adapter_regs.svh"

// Small flip-flop FIFO with valid/ready on both sides
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic             i_flush,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Drain side
   output logic                  o_out_valid,
   output logic      [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;

   // Full and empty come straight from the count
   assign o_in_ready  = (32'(cnt_reg) < DEPTH);
   assign o_out_valid = (cnt_reg != '0);
   assign o_out_data  = mem_reg[rd_reg];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // Storage
   always_ff @(posedge i_clk)
   begin
      if (push)
         mem_reg[wr_reg] <= i_in_data;
   end

   // Pointers wrap at DEPTH, which need not be a power of two
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn || i_flush)
      begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= (32'(wr_reg) == DEPTH - 1) ? '0 : wr_reg + 1'b1;
         if (pop)
            rd_reg <= (32'(rd_reg) == DEPTH - 1) ? '0 : rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule // byte_fifo

module diskette_adapter
   import adapter_pkg::*;
#(
   parameter int CMD_FIFO_DEPTH = 4
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rstn,
   // System bus
   input  wire logic          i_bus_reset,
   input  wire logic [9:0]    i_addr,
   input  wire logic          i_address_ownership,
   input  wire logic          i_io_write_strobe_n,
   input  wire logic          i_io_read_strobe_n,
   input  wire logic          i_dma_grant_2_n,
   input  wire logic          i_terminal_count,
   input  wire logic [7:0]    i_data,
   output logic [7:0]         o_data,
   output logic               o_data_oe,
   output logic               o_dma_request_2,
   output logic               o_interrupt_line_6,
   // Controller core
   input  wire logic          i_op_start,
   input  wire cmd_kind_t     i_cmd_kind,
   input  wire logic          i_op_done,
   input  wire logic          i_byte_request,
   input  wire op_events_t    i_events,
   output result_bytes_t      o_result,
   output logic               o_ctrl_reset,
   output logic               o_cmd_valid,
   output logic [7:0]         o_cmd_data,
   input  wire logic          i_cmd_ready,
   input  wire logic          i_rsp_valid,
   input  wire logic [7:0]    i_rsp_data,
   output logic               o_rsp_ready,
   // Drive cable
   input  wire drive_lines_t  i_drive_lines,
   output logic [3:0]         o_drive_select_n,
   output logic [3:0]         o_motor_enable_n
);
   op_state_t  state_reg;
   logic [7:0] dor_reg;
   logic [7:0] err_reg;
   logic [7:0] err_next;
   logic [7:0] med_reg;
   logic [7:0] med_next;
   logic [7:0] lines_reg;
   logic       wr_low_reg;
   logic       rd_low_reg;
   logic [7:0] wr_data_reg;
   logic       wr_sel_data_reg;
   logic       wr_sel_dor_reg;
   logic       rd_sel_data_reg;
   logic       drq_reg;
   logic       irq_reg;
   logic [7:0] rsp_data_reg;
   logic       rsp_valid_reg;
   logic [7:0] dout_reg;
   logic       oe_reg;
   logic       grant;
   logic       own_addr;
   logic       sel_data;
   logic       sel_state;
   logic       sel_dor;
   logic       wr_done;
   logic       rd_done;
   logic       abort;
   logic       fifo_ready;
   logic [7:0] state_byte;
   logic       is_rd;
   logic       is_wr;
   logic       is_wrdel;
   logic       is_fmt;
   logic       is_scan;

   // Decode; a DMA grant selects the data port whatever the address
   assign grant     = !i_dma_grant_2_n;
   assign own_addr  = !i_address_ownership;
   assign sel_data  = grant ||
                      (own_addr && i_addr == `ADDR_DATA_PORT);
   assign sel_state = !grant && own_addr &&
                      i_addr == `ADDR_STATE_PORT;
   assign sel_dor   = !grant && own_addr &&
                      i_addr == `ADDR_DRIVE_OUT;
   assign wr_done   = wr_low_reg && i_io_write_strobe_n;
   assign rd_done   = rd_low_reg && i_io_read_strobe_n;
   assign abort     = i_bus_reset || !dor_reg[`DOR_CTRL_RUN_BIT];

   // Strobe tracking; address and data are caught while the strobe is low
   // because both may be gone by the time the trailing edge is seen
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         wr_low_reg      <= 1'b0;
         rd_low_reg      <= 1'b0;
         wr_data_reg     <= 8'h00;
         wr_sel_data_reg <= 1'b0;
         wr_sel_dor_reg  <= 1'b0;
         rd_sel_data_reg <= 1'b0;
      end
      else
      begin
         wr_low_reg <= !i_io_write_strobe_n;
         rd_low_reg <= !i_io_read_strobe_n;
         if (!i_io_write_strobe_n)
         begin
            wr_data_reg     <= i_data;
            wr_sel_data_reg <= sel_data;
            wr_sel_dor_reg  <= sel_dor;
         end
         if (!i_io_read_strobe_n)
            rd_sel_data_reg <= sel_data;
      end
   end

   // Drive output register, cleared by either reset
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn || i_bus_reset)
         dor_reg <= `DOR_RESET_VAL;
      else if (wr_done && wr_sel_dor_reg)
         dor_reg <= wr_data_reg;
   end

   // Motor gates selection: a drive without its motor is never selected
   always_comb
   begin
      for (int d = 0; d < 4; d++)
      begin
         o_motor_enable_n[d] = !dor_reg[`DOR_MOTOR_LSB + d];
         o_drive_select_n[d] = !(dor_reg[`DOR_SEL_LSB +: 2] == 2'(d) &&
                                 dor_reg[`DOR_MOTOR_LSB + d]);
      end
   end
   assign o_ctrl_reset = abort;

   // Command bytes queue toward the core; a full queue drops the write,
   // so software must poll the request bit of the state port first
   byte_fifo #(
      .WIDTH (8),
      .DEPTH (CMD_FIFO_DEPTH)
   ) u_cmd_fifo (
      .i_clk       (i_clk),
      .i_rstn      (i_rstn),
      .i_flush     (abort),
      .i_in_valid  (wr_done && wr_sel_data_reg),
      .i_in_data   (wr_data_reg),
      .o_in_ready  (fifo_ready),
      .o_out_valid (o_cmd_valid),
      .o_out_data  (o_cmd_data),
      .i_out_ready (i_cmd_ready)
   );

   // Result byte holding register, emptied by a data port read
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn || abort)
      begin
         rsp_valid_reg <= 1'b0;
         rsp_data_reg  <= 8'h00;
      end
      else if (i_rsp_valid && !rsp_valid_reg)
      begin
         rsp_valid_reg <= 1'b1;
         rsp_data_reg  <= i_rsp_data;
      end
      else if (rd_done && rd_sel_data_reg)
         rsp_valid_reg <= 1'b0;
   end
   assign o_rsp_ready = !rsp_valid_reg;

   // Operation sequence
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn || abort)
         state_reg <= OP_IDLE;
      else
      begin
         case (state_reg)
            OP_IDLE:
               if (i_op_start)
                  state_reg <= OP_EXEC;
            OP_EXEC:
               if (i_op_done)
                  state_reg <= OP_RESULT;
            OP_RESULT:
               if (i_op_start)
                  state_reg <= OP_EXEC;
               else if (rd_done && rd_sel_data_reg)
                  state_reg <= OP_IDLE;
            default:
               state_reg <= OP_IDLE;
         endcase
      end
   end

   // Command qualifiers for the mode-dependent flags
   assign is_rd    = (i_cmd_kind == CMD_READ);
   assign is_wr    = (i_cmd_kind == CMD_WRITE);
   assign is_wrdel = (i_cmd_kind == CMD_WRDEL);
   assign is_fmt   = (i_cmd_kind == CMD_FORMAT);
   assign is_scan  = (i_cmd_kind == CMD_SCAN);

   // Sticky result flags; a new operation clears them but an event in
   // that same cycle still lands
   always_comb
   begin
      err_next = i_op_start ? 8'h00 : err_reg;
      med_next = i_op_start ? 8'h00 : med_reg;
      if (i_events.past_end)
         err_next[`ST_PAST_END_BIT] = 1'b1;
      if (i_events.crc_id || i_events.crc_data)
         err_next[`ST_CRC_BIT] = 1'b1;
      if (i_events.late)
         err_next[`ST_LATE_BIT] = 1'b1;
      if (i_events.not_found && (is_rd || is_wrdel || is_scan))
      begin
         err_next[`ST_MISSING_BIT] = 1'b1;
         if (i_events.cyl_media != i_events.cyl_wanted)
         begin
            med_next[`ST_TRACK_BIT] = 1'b1;
            if (i_events.cyl_media == `BAD_TRACK_VAL)
               med_next[`ST_BAD_BIT] = 1'b1;
         end
      end
      if (i_events.protected_hit && (is_wr || is_wrdel || is_fmt))
         err_next[`ST_BLOCKED_BIT] = 1'b1;
      if (i_events.no_id_mark)
      begin
         err_next[`ST_ID_SYNC_BIT] = 1'b1;
         med_next[`ST_DSYNC_BIT]   = 1'b1;
      end
      if (i_events.deleted_mark && (is_rd || is_scan))
         med_next[`ST_DELETED_BIT] = 1'b1;
      if (i_events.crc_data)
         med_next[`ST_PCRC_BIT] = 1'b1;
      if (is_scan && i_events.scan_equal)
         med_next[`ST_HIT_BIT] = 1'b1;
      if (is_scan && i_events.scan_unmet)
         med_next[`ST_MISS_BIT] = 1'b1;
      if (i_events.no_data_mark)
         med_next[`ST_DSYNC_BIT] = 1'b1;
   end

   // Flag and drive line registers
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn || abort)
      begin
         err_reg   <= 8'h00;
         med_reg   <= 8'h00;
         lines_reg <= 8'h00;
      end
      else
      begin
         err_reg   <= err_next;
         med_reg   <= med_next;
         lines_reg <= i_drive_lines;
      end
   end
   assign o_result = '{error_flags: err_reg, media_flags: med_reg,
                       drive_lines: lines_reg};

   // DMA request: one byte at a time, only when interrupts and DMA enabled
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn || abort)
         drq_reg <= 1'b0;
      else if (grant || (rd_done && rd_sel_data_reg))
         drq_reg <= 1'b0;
      else if (i_byte_request && dor_reg[`DOR_IRQ_EN_BIT])
         drq_reg <= 1'b1;
   end
   assign o_dma_request_2 = drq_reg;

   // Completion or terminal count raises the line; a set beats the clear
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn || abort)
         irq_reg <= 1'b0;
      else if ((state_reg == OP_EXEC && i_op_done) ||
               (grant && i_terminal_count))
         irq_reg <= 1'b1;
      else if (state_reg == OP_RESULT && rd_done && rd_sel_data_reg)
         irq_reg <= 1'b0;
   end
   assign o_interrupt_line_6 = irq_reg && dor_reg[`DOR_IRQ_EN_BIT];

   // State port content
   always_comb
   begin
      state_byte = 8'h00;
      state_byte[`MSR_REQ_BIT]  = fifo_ready || rsp_valid_reg;
      state_byte[`MSR_DIR_BIT]  = rsp_valid_reg;
      state_byte[`MSR_BUSY_BIT] = (state_reg != OP_IDLE);
   end

   // Read data path, registered; unmapped addresses leave the bus alone
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         dout_reg <= 8'h00;
         oe_reg   <= 1'b0;
      end
      else
      begin
         oe_reg <= !i_io_read_strobe_n && (sel_data || sel_state);
         if (sel_data)
            dout_reg <= rsp_data_reg;
         else
            dout_reg <= state_byte;
      end
   end
   assign o_data    = dout_reg;
   assign o_data_oe = oe_reg;

   // Checks
   dor_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_bus_reset |=> dor_reg == 8'h00 && state_reg == OP_IDLE)
      else $error("drive output not cleared by bus reset");
   dor_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_done && wr_sel_dor_reg && !i_bus_reset |=> dor_reg == $past(wr_data_reg))
      else $error("drive output missed a write");
   aen_ignore_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_address_ownership && !grant && !i_io_read_strobe_n |=> !o_data_oe)
      else $error("decode while address not owned");
   read_drive_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !i_io_read_strobe_n && grant |=> o_data_oe ##0 o_data == $past(rsp_data_reg))
      else $error("data port not driven on read");
   grant_drop_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      grant |=> !o_dma_request_2)
      else $error("request held during grant");
   read_drop_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_done && rd_sel_data_reg |=> !drq_reg)
      else $error("request held after data read");
   done_irq_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      state_reg == OP_EXEC && i_op_done && !abort |=> irq_reg ##1 irq_reg || rd_done)
      else $error("completion raised no interrupt");
   id_sync_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_events.no_id_mark && !abort |=> err_reg[0] && med_reg[0])
      else $error("identifier mark flags not paired");
   bad_track_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      med_reg[`ST_BAD_BIT] |-> med_reg[`ST_TRACK_BIT] && err_reg[`ST_MISSING_BIT])
      else $error("bad track without mismatch");
   drive_lines_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !abort |=> o_result.drive_lines == $past(i_drive_lines))
      else $error("drive lines not mirrored");
endmodule // diskette_adapter
`default_nettype wire

// File: sim/dma_model.sv
// DMA controller stand-in: grants adapter requests after a delay, only while enabled
`timescale 1ns/1ps
`default_nettype none
module dma_model #(
   parameter int DLY = 2
) (
   input  wire logic i_clk,
   input  wire logic i_en,
   input  wire logic i_tc_arm,
   input  wire logic i_drq,
   output logic      o_grant_n,
   output logic      o_tc
);
   // Grant is held two cycles so the adapter samples it on a settled edge
   initial
   begin
      o_grant_n = 1'b1;
      o_tc = 1'b0;
      forever
      begin
         @(negedge i_clk);
         if (i_en && i_drq)
         begin
            repeat (DLY) @(negedge i_clk);
            o_grant_n = 1'b0;
            o_tc = i_tc_arm;
            repeat (2) @(negedge i_clk);
            o_grant_n = 1'b1;
            o_tc = 1'b0;
         end
      end
   end
endmodule // dma_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the diskette adapter host port
`timescale 1ns/1ps
`default_nettype none
module testbench
   import adapter_pkg::*;
;
   logic          clk = 0, rstn = 0, bus_rst = 0, own = 0, wr_n = 1, rd_n = 1;
   logic [9:0]    addr = '0;
   logic [7:0]    wdata = '0, rdata, rv, cmd_data;
   logic          oe, ro, drq, irq, grant_n, tc, ctrl_rst, cmd_valid, rsp_ready;
   logic          op_start = 0, op_done = 0, byte_req = 0, cmd_ready = 0, rsp_valid = 0;
   logic          dma_en = 0, tc_arm = 0;
   cmd_kind_t     cmd = CMD_READ;
   op_events_t    events = '0;
   result_bytes_t res;
   drive_lines_t  lines = 8'ha5;
   drive_lines_t  line_bus;
   logic [3:0]    sel_n, mot_n;
   int            err_total = 0, checks_done = 0;

   // Drive cable: with no drive selected every drive releases its lines to inactive
   assign line_bus = (&sel_n) ? '0 : lines;

   // Clock of 4 ns
   always #2 clk = ~clk;

   diskette_adapter DUT (.i_clk(clk), .i_rstn(rstn), .i_bus_reset(bus_rst), .i_addr(addr),
      .i_address_ownership(own), .i_io_write_strobe_n(wr_n), .i_io_read_strobe_n(rd_n),
      .i_dma_grant_2_n(grant_n), .i_terminal_count(tc), .i_data(wdata), .o_data(rdata),
      .o_data_oe(oe), .o_dma_request_2(drq), .o_interrupt_line_6(irq), .i_op_start(op_start),
      .i_cmd_kind(cmd), .i_op_done(op_done), .i_byte_request(byte_req), .i_events(events),
      .o_result(res), .o_ctrl_reset(ctrl_rst), .o_cmd_valid(cmd_valid), .o_cmd_data(cmd_data),
      .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid), .i_rsp_data(8'h5a),
      .o_rsp_ready(rsp_ready), .i_drive_lines(line_bus), .o_drive_select_n(sel_n),
      .o_motor_enable_n(mot_n));

   dma_model DMA (.i_clk(clk), .i_en(dma_en), .i_tc_arm(tc_arm), .i_drq(drq),
      .o_grant_n(grant_n), .o_tc(tc));

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One strobe cycle; the request is held until the edge after release commits it
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic o);
      @(negedge clk);
      addr = a;
      wdata = d;
      own = o;
      if (w)
         wr_n = 0;
      else
         rd_n = 0;
      repeat (2) @(negedge clk);
      rv = rdata;
      ro = oe;
      wr_n = 1;
      rd_n = 1;
      @(negedge clk);
      own = 0;
   endtask

   // Start an operation, pulse one set of events, then read the flags back
   task automatic ev(input cmd_kind_t k, input logic [10:0] f, input logic [7:0] cm,
                     input logic [7:0] e1, input logic [7:0] e2);
      @(negedge clk);
      op_start = 1;
      cmd = k;
      @(negedge clk);
      op_start = 0;
      events = {f, cm, 8'h03};
      @(negedge clk);
      events = '0;
      @(negedge clk);
      chk(res.error_flags, e1);
      chk(res.media_flags, e2);
   endtask

   task automatic t_reset;
      chk({mot_n, sel_n}, 8'hff);
      chk({ctrl_rst, irq, drq, 5'h0}, 8'h80);
      $display("test reset done");
   endtask

   // Selection follows the motor bits; writes and reads without address ownership or to unreadable ports are ignored
   task automatic t_dor;
      bus(1, 10'h3f2, 8'h2d, 0);
      chk({mot_n, sel_n}, 8'hdd);
      bus(1, 10'h3f2, 8'h1c, 0);
      chk({mot_n, sel_n}, 8'hee);
      chk({7'h0, ctrl_rst}, 8'h00);
      bus(1, 10'h3f2, 8'h00, 1);
      chk({mot_n, sel_n}, 8'hee);
      bus(0, 10'h3f4, 8'h00, 1);
      chk({7'h0, ro}, 8'h00);
      bus(0, 10'h3f2, 8'h00, 0);
      chk({7'h0, ro}, 8'h00);
      bus(0, 10'h3f0, 8'h00, 0);
      chk({7'h0, ro}, 8'h00);
      $display("test output register done");
   endtask

   // Fill the command buffer while the core stalls, then drain it
   task automatic t_fifo;
      for (int i = 0; i < 4; i++)
         bus(1, 10'h3f5, 8'h10 + 8'(i), 0);
      bus(0, 10'h3f4, 8'h00, 0);
      chk(rv, 8'h00);
      bus(1, 10'h3f5, 8'h77, 0);
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk);
         chk(cmd_data, 8'h10 + 8'(i));
         cmd_ready = 1;
         @(negedge clk);
         cmd_ready = 0;
      end
      chk({7'h0, cmd_valid}, 8'h00);
      bus(0, 10'h3f4, 8'h00, 0);
      chk(rv, 8'h80);
      $display("test command buffer done");
   endtask

   task automatic t_flags;
      ev(CMD_READ, 11'h400, 8'h03, 8'h80, 8'h00);
      ev(CMD_READ, 11'h200, 8'h03, 8'h20, 8'h00);
      ev(CMD_READ, 11'h100, 8'h03, 8'h20, 8'h20);
      ev(CMD_READ, 11'h080, 8'h03, 8'h10, 8'h00);
      ev(CMD_WRDEL, 11'h040, 8'h03, 8'h04, 8'h00);
      ev(CMD_WRITE, 11'h040, 8'h03, 8'h00, 8'h00);
      ev(CMD_SCAN, 11'h040, 8'h07, 8'h04, 8'h10);
      ev(CMD_READ, 11'h040, 8'hff, 8'h04, 8'h12);
      ev(CMD_FORMAT, 11'h020, 8'h03, 8'h02, 8'h00);
      ev(CMD_READ, 11'h020, 8'h03, 8'h00, 8'h00);
      ev(CMD_READ, 11'h010, 8'h03, 8'h01, 8'h01);
      ev(CMD_READ, 11'h008, 8'h03, 8'h00, 8'h01);
      ev(CMD_SCAN, 11'h004, 8'h03, 8'h00, 8'h40);
      ev(CMD_WRITE, 11'h004, 8'h03, 8'h00, 8'h00);
      ev(CMD_SCAN, 11'h002, 8'h03, 8'h00, 8'h08);
      ev(CMD_SCAN, 11'h001, 8'h03, 8'h00, 8'h04);
      lines = 8'h5a;
      repeat (2) @(negedge clk);
      chk(res.drive_lines, 8'h5a);
      $display("test result flags done");
   endtask

   task automatic t_irq;
      @(negedge clk);
      op_start = 1;
      @(negedge clk);
      op_start = 0;
      op_done = 1;
      @(negedge clk);
      op_done = 0;
      rsp_valid = 1;
      @(negedge clk);
      rsp_valid = 0;
      chk({7'h0, irq}, 8'h01);
      chk({7'h0, rsp_ready}, 8'h00);
      bus(1, 10'h3f2, 8'h14, 0);
      chk({7'h0, irq}, 8'h00);
      bus(1, 10'h3f2, 8'h1c, 0);
      chk({7'h0, irq}, 8'h01);
      bus(0, 10'h3f4, 8'h00, 0);
      chk(rv, 8'hd0);
      bus(0, 10'h3f5, 8'h00, 0);
      chk(rv, 8'h5a);
      chk({7'h0, ro}, 8'h01);
      chk({7'h0, irq}, 8'h00);
      chk({7'h0, rsp_ready}, 8'h01);
      $display("test interrupt done");
   endtask

   task automatic t_dma;
      int n;
      @(negedge clk);
      byte_req = 1;
      @(negedge clk);
      byte_req = 0;
      chk({7'h0, drq}, 8'h01);
      bus(0, 10'h3f5, 8'h00, 0);
      chk({7'h0, drq}, 8'h00);
      tc_arm = 1;
      dma_en = 1;
      @(negedge clk);
      byte_req = 1;
      @(negedge clk);
      byte_req = 0;
      n = 0;
      while (grant_n && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      // A read strobe inside the grant reaches the data port whatever the address
      @(negedge clk);
      rd_n = 0;
      @(negedge clk);
      chk(rdata, 8'h5a);
      rd_n = 1;
      chk({6'h0, drq, irq}, 8'h01);
      dma_en = 0;
      $display("test dma done");
   endtask

   // Bus reset in mid-run, with the drive 0 motor on and an interrupt pending
   task automatic t_busrst;
      @(negedge clk);
      bus_rst = 1;
      @(negedge clk);
      bus_rst = 0;
      chk({mot_n, sel_n}, 8'hff);
      chk({ctrl_rst, irq, 6'h0}, 8'h80);
      $display("test bus reset done");
   endtask

   // Main sequence
   initial
   begin
      repeat (8) @(negedge clk);
      rstn = 1;
      t_reset();
      t_dor();
      t_fifo();
      t_flags();
      t_irq();
      t_dma();
      t_busrst();
      print_verdict();
   end

   // Watchdog far beyond the expected few hundred cycles
   initial
   begin
      #80000;
      err_total++;
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
